// [hdl/host_ec_message_interface.sv]
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - After reset the block runs single-byte full-duplex legacy mode.
// - A four-byte full-duplex mode can be selected instead of legacy mode.
// - Host write of the mode's last data byte or of the command to an empty input buffer pulses the controller input-full interrupt.
// - Host read emptying the output buffer pulses the controller empty interrupt.
// - Host empty interrupt is asserted while the output-full flag is clear.
// - SMI and SCI event bits are plain software flags, no hardware events.
// - System reset returns every register and all logic to defaults.
// - Block marks itself low-power whenever no bus access targets it.
// - All register access runs on the one host interface clock.
// - Host and controller each reach the registers through their own view.
// - Host data-byte-0 write clears command flag, command write sets it.
// - Both directions transfer concurrently without disturbing each other.
module host_ec_message_interface (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Host-side register view
   input wire logic host_cyc_i,
   input wire logic host_stb_i,
   input wire logic host_we_i,
   input wire logic [ec_msg_pkg::ADR_W-1:0] host_adr_i,
   input wire logic [31:0] host_dat_i,
   input wire logic [3:0] host_sel_i,
   output logic host_ack_o,
   output logic [31:0] host_dat_o,
   // Controller-side register view
   input wire logic ec_cyc_i,
   input wire logic ec_stb_i,
   input wire logic ec_we_i,
   input wire logic [ec_msg_pkg::ADR_W-1:0] ec_adr_i,
   input wire logic [31:0] ec_dat_i,
   input wire logic [3:0] ec_sel_i,
   output logic ec_ack_o,
   output logic [31:0] ec_dat_o,
   // Events
   output logic input_buffer_full_irq_o,
   output logic output_buffer_empty_irq_o,
   output logic host_output_empty_irq_o,
   output logic idle_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic in_bank(input logic [ec_msg_pkg::IDX_W-1:0] idx,
                                    input logic [ec_msg_pkg::IDX_W-1:0] base);
      in_bank = (idx[ec_msg_pkg::IDX_W-1:2] == base[ec_msg_pkg::IDX_W-1:2]);
   endfunction

   function automatic logic [1:0] last_of(input ec_msg_pkg::mode_t m);
      last_of = (m == ec_msg_pkg::MODE_FOUR) ? ec_msg_pkg::LAST_BYTE_FOUR
                                              : ec_msg_pkg::LAST_BYTE_LEGACY;
   endfunction

   function automatic logic [7:0] status_of(input logic [7:0] sw, input logic out_full,
                                            input logic in_full, input logic cmd);
      logic [7:0] s;
      s = sw & ec_msg_pkg::STS_SW_MASK;
      s[ec_msg_pkg::STS_OUT_FULL_BIT] = out_full;
      s[ec_msg_pkg::STS_IN_FULL_BIT] = in_full;
      s[ec_msg_pkg::STS_CMD_BIT] = cmd;
      status_of = s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0] os2ec_q [4];
   logic [7:0] ec2os_q [4];
   logic in_full_q;
   logic out_full_q;
   logic cmd_q;
   logic [7:0] sw_sts_q;
   ec_msg_pkg::mode_t mode_q;

   logic in_full_d;
   logic out_full_d;
   logic in_full_set;
   logic in_full_clr;
   logic out_full_set;
   logic out_full_clr;
   logic [1:0] last;

   logic h_wr;
   logic h_rd;
   logic [ec_msg_pkg::IDX_W-1:0] h_idx;
   logic [7:0] h_wdat;
   logic [7:0] h_rdat;
   logic e_wr;
   logic e_rd;
   logic [ec_msg_pkg::IDX_W-1:0] e_idx;
   logic [7:0] e_wdat;
   logic [7:0] e_rdat;

   ////////////////////////////////////////////////////////////////////////////
   // Two register views on one clock

   wb_reg_port u_host_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(host_cyc_i),
      .stb_i(host_stb_i),
      .we_i(host_we_i),
      .adr_i(host_adr_i),
      .dat_i(host_dat_i),
      .sel_i(host_sel_i),
      .ack_o(host_ack_o),
      .dat_o(host_dat_o),
      .rdata_i(h_rdat),
      .wr_o(h_wr),
      .rd_o(h_rd),
      .idx_o(h_idx),
      .wdata_o(h_wdat)
   );

   wb_reg_port u_ec_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .cyc_i(ec_cyc_i),
      .stb_i(ec_stb_i),
      .we_i(ec_we_i),
      .adr_i(ec_adr_i),
      .dat_i(ec_dat_i),
      .sel_i(ec_sel_i),
      .ack_o(ec_ack_o),
      .dat_o(ec_dat_o),
      .rdata_i(e_rdat),
      .wr_o(e_wr),
      .rd_o(e_rd),
      .idx_o(e_idx),
      .wdata_o(e_wdat)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexers

   always_comb begin
      h_rdat = 8'h00;
      if (in_bank(h_idx, ec_msg_pkg::HOST_DATA0_IDX)) begin
         h_rdat = ec2os_q[h_idx[1:0]];
      end else if (h_idx == ec_msg_pkg::HOST_CMD_STS_IDX) begin
         h_rdat = status_of(sw_sts_q, out_full_q, in_full_q, cmd_q);
      end else if (h_idx == ec_msg_pkg::HOST_BYTE_CTL_IDX) begin
         h_rdat = {7'h00, mode_q == ec_msg_pkg::MODE_FOUR};
      end
   end

   always_comb begin
      e_rdat = 8'h00;
      if (in_bank(e_idx, ec_msg_pkg::EC_RX0_IDX)) begin
         e_rdat = os2ec_q[e_idx[1:0]];
      end else if (e_idx == ec_msg_pkg::EC_STATUS_IDX) begin
         e_rdat = status_of(sw_sts_q, out_full_q, in_full_q, cmd_q);
      end else if (e_idx == ec_msg_pkg::EC_BYTE_CTL_IDX) begin
         e_rdat = {7'h00, mode_q == ec_msg_pkg::MODE_FOUR};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer flags; a set in the same cycle as a clear wins

   always_comb begin
      last = last_of(mode_q);
      in_full_set = h_wr && ((in_bank(h_idx, ec_msg_pkg::HOST_DATA0_IDX) && h_idx[1:0] == last)
                || h_idx == ec_msg_pkg::HOST_CMD_STS_IDX);
      in_full_clr = e_rd && in_bank(e_idx, ec_msg_pkg::EC_RX0_IDX)
                && (e_idx[1:0] == last || (cmd_q && e_idx[1:0] == 2'h0));
      out_full_set = e_wr && in_bank(e_idx, ec_msg_pkg::EC_TX0_IDX)
                && e_idx[1:0] == last;
      out_full_clr = h_rd && in_bank(h_idx, ec_msg_pkg::HOST_DATA0_IDX)
                && h_idx[1:0] == last;
      in_full_d = in_full_set || (in_full_q && !in_full_clr);
      out_full_d = out_full_set || (out_full_q && !out_full_clr);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_full_q <= 1'b0;
         out_full_q <= 1'b0;
      end else begin
         in_full_q <= in_full_d;
         out_full_q <= out_full_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host-to-controller buffer and command flag

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            os2ec_q[i] <= ec_msg_pkg::DATA_RESET;
         end
      end else if (h_wr && in_bank(h_idx, ec_msg_pkg::HOST_DATA0_IDX)) begin
         os2ec_q[h_idx[1:0]] <= h_wdat;
      end else if (h_wr && h_idx == ec_msg_pkg::HOST_CMD_STS_IDX) begin
         os2ec_q[0] <= h_wdat;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q <= 1'b0;
      end else if (h_wr && h_idx == ec_msg_pkg::HOST_CMD_STS_IDX) begin
         cmd_q <= 1'b1;
      end else if (h_wr && h_idx == ec_msg_pkg::HOST_DATA0_IDX) begin
         cmd_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Controller-to-host buffer, software flags and mode

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 4; i++) begin
            ec2os_q[i] <= ec_msg_pkg::DATA_RESET;
         end
      end else if (e_wr && in_bank(e_idx, ec_msg_pkg::EC_TX0_IDX)) begin
         ec2os_q[e_idx[1:0]] <= e_wdat;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sw_sts_q <= ec_msg_pkg::STS_SW_RESET;
      end else if (e_wr && e_idx == ec_msg_pkg::EC_STATUS_IDX) begin
         sw_sts_q <= e_wdat & ec_msg_pkg::STS_SW_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= ec_msg_pkg::MODE_LEGACY;
      end else if (e_wr && e_idx == ec_msg_pkg::EC_BYTE_CTL_IDX) begin
         mode_q <= e_wdat[ec_msg_pkg::BYTE_CTL_FOUR_BIT] ? ec_msg_pkg::MODE_FOUR
                                                         : ec_msg_pkg::MODE_LEGACY;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupts and power state

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         input_buffer_full_irq_o <= 1'b0;
         output_buffer_empty_irq_o <= 1'b0;
         host_output_empty_irq_o <= 1'b1;
      end else begin
         input_buffer_full_irq_o <= in_full_d && !in_full_q;
         output_buffer_empty_irq_o <= out_full_q && !out_full_d;
         host_output_empty_irq_o <= !out_full_d;
      end
   end

   // Idle whenever neither view has a cycle open
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_o <= 1'b1;
      end else begin
         idle_o <= !host_cyc_i && !ec_cyc_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_in_full_rise: assert property (@(posedge clk_i) disable iff (rst_i)
      input_buffer_full_irq_o == $rose(in_full_q))
      else $error("input full interrupt does not match flag rise");

   a_empty_irq_fall: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(out_full_q) |-> output_buffer_empty_irq_o)
      else $error("output empty interrupt missing on flag fall");

   a_host_empty_level: assert property (@(posedge clk_i) disable iff (rst_i)
      host_output_empty_irq_o == !out_full_q)
      else $error("host empty interrupt disagrees with output full flag");

   a_reset_defaults: assert property (@(posedge clk_i)
      rst_i |=> !in_full_q && !out_full_q && !cmd_q && sw_sts_q == 8'h00
                && mode_q == ec_msg_pkg::MODE_LEGACY && !host_ack_o && !ec_ack_o)
      else $error("state not at default after reset");

   a_cmd_write_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      h_wr && h_idx == ec_msg_pkg::HOST_CMD_STS_IDX |=> cmd_q && in_full_q ##1 host_ack_o == 1'b0)
      else $error("command write did not set command and input full");

   a_data_clears_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      h_wr && h_idx == ec_msg_pkg::HOST_DATA0_IDX |=> !cmd_q && os2ec_q[0] == $past(h_wdat))
      else $error("data write did not clear command flag");

   a_ec_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      e_rd && e_idx == ec_msg_pkg::EC_RX0_IDX + 10'(last_of(mode_q)) && !in_full_set
      |=> !in_full_q)
      else $error("controller read did not clear input full");

   a_ec_write_sets: assert property (@(posedge clk_i) disable iff (rst_i)
      e_wr && e_idx == ec_msg_pkg::EC_TX0_IDX + 10'(last_of(mode_q)) |=> out_full_q)
      else $error("controller write did not set output full");

   a_legacy_byte_three: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_q == ec_msg_pkg::MODE_LEGACY && !in_full_q && e_idx != ec_msg_pkg::EC_BYTE_CTL_IDX
      && h_wr && h_idx == ec_msg_pkg::HOST_DATA0_IDX + 10'h3 |=> !in_full_q)
      else $error("legacy mode raised input full on byte three");

   a_four_byte_wait: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_q == ec_msg_pkg::MODE_FOUR && !in_full_q && h_wr
      && h_idx == ec_msg_pkg::HOST_DATA0_IDX |=> !in_full_q)
      else $error("four-byte mode raised input full on byte zero");

   a_sw_flags_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !(e_wr && e_idx == ec_msg_pkg::EC_STATUS_IDX) |=> $stable(sw_sts_q))
      else $error("software flags changed without a controller write");

   a_idle_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (host_cyc_i || ec_cyc_i) |=> !idle_o)
      else $error("idle shown during an open bus cycle");

   a_duplex_isolated: assert property (@(posedge clk_i) disable iff (rst_i)
      h_wr && in_bank(h_idx, ec_msg_pkg::HOST_DATA0_IDX) |=> $stable(ec2os_q[0])
      || $past(e_wr))
      else $error("host write disturbed the outgoing buffer");

   a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      host_ack_o |=> !host_ack_o)
      else $error("host ack held longer than one cycle");

   a_ec_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
      ec_ack_o |=> !ec_ack_o)
      else $error("controller ack held longer than one cycle");

   a_empty_irq_exact: assert property (@(posedge clk_i) disable iff (rst_i)
      !$past(rst_i) |-> output_buffer_empty_irq_o == $fell(out_full_q))
      else $error("output empty interrupt without a flag fall");

   a_full_rise_source: assert property (@(posedge clk_i) disable iff (rst_i)
      !h_wr |=> !$rose(in_full_q))
      else $error("input full rose without a host write");

   a_cmd_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
      e_rd && cmd_q && e_idx == ec_msg_pkg::EC_RX0_IDX && !in_full_set |=> !in_full_q)
      else $error("controller read of a command did not clear input full");

endmodule // host_ec_message_interface

// [hdl/ec_msg_pkg.sv]
package ec_msg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus geometry
   localparam int ADR_W = 12;
   localparam int IDX_W = 10;

   ////////////////////////////////////////////////////////////////////////////
   // Register indexes, byte address is four times the index
   localparam logic [IDX_W-1:0] HOST_DATA0_IDX = 10'h000;
   localparam logic [IDX_W-1:0] HOST_CMD_STS_IDX = 10'h004;
   localparam logic [IDX_W-1:0] HOST_BYTE_CTL_IDX = 10'h005;
   localparam logic [IDX_W-1:0] EC_TX0_IDX = 10'h100;
   localparam logic [IDX_W-1:0] EC_STATUS_IDX = 10'h104;
   localparam logic [IDX_W-1:0] EC_BYTE_CTL_IDX = 10'h105;
   localparam logic [IDX_W-1:0] EC_RX0_IDX = 10'h108;

   ////////////////////////////////////////////////////////////////////////////
   // Status byte layout
   localparam int STS_OUT_FULL_BIT = 0;
   localparam int STS_IN_FULL_BIT = 1;
   localparam int STS_CMD_BIT = 3;
   localparam int STS_SCI_BIT = 5;
   localparam int STS_SMI_BIT = 6;
   localparam logic [7:0] STS_SW_MASK = 8'hf4;

   // Byte control layout
   localparam int BYTE_CTL_FOUR_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [7:0] STS_SW_RESET = 8'h00;

   // Last byte of a transfer per mode
   localparam logic [1:0] LAST_BYTE_LEGACY = 2'h0;
   localparam logic [1:0] LAST_BYTE_FOUR = 2'h3;

   typedef enum logic {MODE_LEGACY, MODE_FOUR} mode_t;

endpackage

// [hdl/wb_reg_port.sv]
`timescale 1ns/1ps
module wb_reg_port (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ec_msg_pkg::ADR_W-1:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   output logic ack_o,
   output logic [31:0] dat_o,
   // Register file side
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [ec_msg_pkg::IDX_W-1:0] idx_o,
   output logic [7:0] wdata_o
);

   logic take;
   logic aligned;

   // One access per cycle of the bus; unaligned addresses answer but do nothing
   assign take = cyc_i && stb_i && !ack_o;
   assign aligned = (adr_i[1:0] == 2'h0);
   assign wr_o = take && aligned && we_i && sel_i[0];
   assign rd_o = take && aligned && !we_i;
   assign idx_o = adr_i[ec_msg_pkg::ADR_W-1:2];
   assign wdata_o = dat_i[7:0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (rd_o) begin
         dat_o <= {24'h0, rdata_i};
      end else begin
         dat_o <= 32'h0;
      end
   end

endmodule // wb_reg_port

// [tb/wb_host_model.sv]
`timescale 1ns/1ps
module wb_host_model (
   // Clock
   input wire logic clk_i,
   // Wishbone master
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [ec_msg_pkg::ADR_W-1:0] adr_o,
   output logic [31:0] dat_o,
   output logic [3:0] sel_o,
   input wire logic ack_i,
   input wire logic [31:0] dat_i
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 12'h000;
      dat_o = 32'h00000000;
      sel_o = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // One classic cycle, entered just after a rising edge
   task automatic xfer(input logic we, input logic [ec_msg_pkg::IDX_W-1:0] idx,
                       input logic [7:0] wd, output logic [7:0] rd);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= we;
      adr_o <= {idx, 2'b00};
      dat_o <= {24'h000000, wd};
      sel_o <= 4'h1;
      do @(posedge clk_i); while (ack_i !== 1'b1);
      rd = dat_i[7:0];
      // Released lines stop showing the old request
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= ~we_o;
      adr_o <= ~adr_o;
      dat_o <= ~dat_o;
      sel_o <= 4'h0;
      @(posedge clk_i);
   endtask

   // Poll the status byte until one flag reaches the wanted level
   task automatic wait_sts(input int bit_n, input logic val);
      logic [7:0] s;
      s = {8{~val}};
      while (s[bit_n] !== val) xfer(1'b0, ec_msg_pkg::HOST_CMD_STS_IDX, 8'h00, s);
   endtask
endmodule // wb_host_model

// [tb/host_ec_message_interface_tb_top.sv]
`timescale 1ns/1ps
module host_ec_message_interface_tb_top;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire h_cyc, h_stb, h_we, h_ack, e_cyc, e_stb, e_we, e_ack;
   wire [11:0] h_adr, e_adr;
   wire [31:0] h_dw, h_dr, e_dw, e_dr;
   wire [3:0] h_sel, e_sel;
   wire in_full_irq, out_empty_irq, h_empty, idle;
   int mismatches = 0;
   int total_checks = 0;
   int in_full_n = 0;
   int out_empty_n = 0;
   int cycles = 0;

   always #5 clk_i = ~clk_i;

   wb_host_model host (.clk_i(clk_i), .cyc_o(h_cyc), .stb_o(h_stb), .we_o(h_we), .adr_o(h_adr),
      .dat_o(h_dw), .sel_o(h_sel), .ack_i(h_ack), .dat_i(h_dr));
   wb_host_model ec (.clk_i(clk_i), .cyc_o(e_cyc), .stb_o(e_stb), .we_o(e_we), .adr_o(e_adr),
      .dat_o(e_dw), .sel_o(e_sel), .ack_i(e_ack), .dat_i(e_dr));
   host_ec_message_interface DUT (.clk_i(clk_i), .rst_i(rst_i),
      .host_cyc_i(h_cyc), .host_stb_i(h_stb), .host_we_i(h_we), .host_adr_i(h_adr),
      .host_dat_i(h_dw), .host_sel_i(h_sel), .host_ack_o(h_ack), .host_dat_o(h_dr),
      .ec_cyc_i(e_cyc), .ec_stb_i(e_stb), .ec_we_i(e_we), .ec_adr_i(e_adr),
      .ec_dat_i(e_dw), .ec_sel_i(e_sel), .ec_ack_o(e_ack), .ec_dat_o(e_dr),
      .input_buffer_full_irq_o(in_full_irq), .output_buffer_empty_irq_o(out_empty_irq),
      .host_output_empty_irq_o(h_empty), .idle_o(idle));

   ////////////////////////////////////////////////////////////////////////////
   // Checking and access tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic hw(input logic [9:0] i, input logic [7:0] d);
      logic [7:0] x;
      host.xfer(1'b1, i, d, x);
   endtask

   task automatic hr(input logic [9:0] i, input logic [7:0] e);
      logic [7:0] x;
      host.xfer(1'b0, i, 8'h00, x);
      chk({24'h0, x}, {24'h0, e});
   endtask

   task automatic ew(input logic [9:0] i, input logic [7:0] d);
      logic [7:0] x;
      ec.xfer(1'b1, i, d, x);
   endtask

   task automatic er(input logic [9:0] i, input logic [7:0] e);
      logic [7:0] x;
      ec.xfer(1'b0, i, 8'h00, x);
      chk({24'h0, x}, {24'h0, e});
   endtask

   // Interrupt pulse counters and hang limit
   always @(posedge clk_i) begin
      if (in_full_irq === 1'b1)
         in_full_n++;
      if (out_empty_irq === 1'b1)
         out_empty_n++;
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Test sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      er(ec_msg_pkg::EC_STATUS_IDX, 8'h00);
      er(ec_msg_pkg::EC_BYTE_CTL_IDX, 8'h00);
      hr(ec_msg_pkg::HOST_BYTE_CTL_IDX, 8'h00);
      chk({31'h0, h_empty}, 32'h1);
      // Idle is registered one edge after the bus goes quiet
      @(posedge clk_i);
      chk({31'h0, idle}, 32'h1);
      // Legacy data toward the controller
      host.wait_sts(ec_msg_pkg::STS_IN_FULL_BIT, 1'b0);
      hw(ec_msg_pkg::HOST_DATA0_IDX, 8'ha5);
      chk(in_full_n, 1);
      hr(ec_msg_pkg::HOST_CMD_STS_IDX, 8'h02);
      er(ec_msg_pkg::EC_RX0_IDX, 8'ha5);
      er(ec_msg_pkg::EC_STATUS_IDX, 8'h00);
      hw(ec_msg_pkg::HOST_DATA0_IDX + 10'h3, 8'h33);
      hr(ec_msg_pkg::HOST_CMD_STS_IDX, 8'h00);
      // Command then data
      hw(ec_msg_pkg::HOST_CMD_STS_IDX, 8'h5a);
      er(ec_msg_pkg::EC_STATUS_IDX, 8'h0a);
      er(ec_msg_pkg::EC_RX0_IDX, 8'h5a);
      hw(ec_msg_pkg::HOST_DATA0_IDX, 8'hc3);
      er(ec_msg_pkg::EC_STATUS_IDX, 8'h02);
      er(ec_msg_pkg::EC_RX0_IDX, 8'hc3);
      chk(in_full_n, 3);
      // Both directions pending at once
      ew(ec_msg_pkg::EC_TX0_IDX, 8'h3c);
      chk({31'h0, h_empty}, 32'h0);
      hw(ec_msg_pkg::HOST_DATA0_IDX, 8'h11);
      hr(ec_msg_pkg::HOST_CMD_STS_IDX, 8'h03);
      host.wait_sts(ec_msg_pkg::STS_OUT_FULL_BIT, 1'b1);
      hr(ec_msg_pkg::HOST_DATA0_IDX, 8'h3c);
      chk(out_empty_n, 1);
      chk({31'h0, h_empty}, 32'h1);
      er(ec_msg_pkg::EC_RX0_IDX, 8'h11);
      // Software event flags
      ew(ec_msg_pkg::EC_STATUS_IDX, 8'hff);
      hr(ec_msg_pkg::HOST_CMD_STS_IDX, 8'hf4);
      chk(in_full_n + out_empty_n, 5);
      ew(ec_msg_pkg::EC_STATUS_IDX, 8'h00);
      // Four-byte mode in both directions
      ew(ec_msg_pkg::EC_BYTE_CTL_IDX, 8'h01);
      hr(ec_msg_pkg::HOST_BYTE_CTL_IDX, 8'h01);
      for (int i = 0; i < 4; i++) begin
         hw(ec_msg_pkg::HOST_DATA0_IDX + 10'(i), 8'h10 + 8'(i));
         ew(ec_msg_pkg::EC_TX0_IDX + 10'(i), 8'h20 + 8'(i));
         hr(ec_msg_pkg::HOST_CMD_STS_IDX, (i == 3) ? 8'h03 : 8'h00);
      end
      for (int i = 0; i < 4; i++) begin
         er(ec_msg_pkg::EC_RX0_IDX + 10'(i), 8'h10 + 8'(i));
         hr(ec_msg_pkg::HOST_DATA0_IDX + 10'(i), 8'h20 + 8'(i));
      end
      hr(ec_msg_pkg::HOST_CMD_STS_IDX, 8'h00);
      chk(out_empty_n, 2);
      chk(in_full_n, 5);
      er(10'h106, 8'h00);
      // Reset in mid-run with both buffers full
      hw(ec_msg_pkg::HOST_DATA0_IDX + 10'h3, 8'h77);
      ew(ec_msg_pkg::EC_TX0_IDX + 10'h3, 8'h88);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      er(ec_msg_pkg::EC_STATUS_IDX, 8'h00);
      er(ec_msg_pkg::EC_BYTE_CTL_IDX, 8'h00);
      hr(ec_msg_pkg::HOST_DATA0_IDX, 8'h00);
      chk({31'h0, h_empty}, 32'h1);
      @(posedge clk_i);
      chk({31'h0, idle}, 32'h1);
      summarize();
   end
endmodule // host_ec_message_interface_tb_top
